// ==== common/swdt_pkg.sv ====
// Package for the system watchdog timer: register map, fields, reset values, timing
package swdt_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CONFIG_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] COUNT_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_STS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h14;
  // Command bits in the control register (write-only strobes)
  localparam int CMD_INIT_BIT  = 0;
  localparam int CMD_CFG_BIT   = 1;
  localparam int CMD_ARM_BIT   = 2;
  localparam int CMD_KICK_BIT  = 3;
  localparam int CMD_HALT_BIT  = 4;
  // Configuration fields
  localparam int CFG_TICK_LSB  = 0;
  localparam int CFG_UNIT_BIT  = 8;
  // Status fields
  localparam int ST_OK_BIT     = 0;
  localparam int ST_FAIL_BIT   = 1;
  localparam int ST_INIT_BIT   = 2;
  localparam int ST_ARMED_BIT  = 3;
  // Interrupt status bits
  localparam int IRQ_OK_BIT    = 0;
  localparam int IRQ_FAIL_BIT  = 1;
  localparam int IRQ_EXP_BIT   = 2;
  localparam int IRQ_W         = 3;
  // Reset values
  localparam logic [7:0] TICK_RST  = 8'h01;
  localparam logic       UNIT_RST  = 1'b0;
  localparam logic [2:0] MSK_RST   = 3'h0;
  // Timing
  localparam int CLK_HZ        = 25000000;
  localparam int SEC_NS        = 1000000000;
  localparam int CLK_NS        = 40;
  localparam int SEC_CYCLES    = SEC_NS / CLK_NS;
  localparam int MIN_SECONDS   = 60;
  localparam int RST_PULSE_NS  = 1000;
  localparam int RST_CYCLES    = RST_PULSE_NS / CLK_NS;
  // Controller states
  typedef enum logic [2:0] {
    SWDT_IDLE  = 3'b001,
    SWDT_ARMED = 3'b010,
    SWDT_FIRE  = 3'b100
  } swdt_state_t;
endpackage

// ==== core/swdt_core.sv ====
// System watchdog timer core: command port, countdown, system reset, interrupts
// Summary of operation
// - Expiry of the armed counter drives a system reset pulse.
// - Timeout ticks are eight bits, 1 to 255; zero is refused.
// - Unit selector 0 gives one-second ticks.
// - Unit selector 1 gives one-minute ticks.
// - Counting starts only after the arm command; idle before it.
// - Kick reloads the full programmed timeout and restarts counting.
// - Halt stops the counter; no expiry until armed again.
// - Each command reports success or failure to the host.
module swdt_core #(
  parameter int SEC_CYC = swdt_pkg::SEC_CYCLES,
  parameter int MIN_SEC = swdt_pkg::MIN_SECONDS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // System side
  output logic             sysReset,
  output logic             irq
);
  localparam int PW = $clog2(SEC_CYC + 1);

  swdt_pkg::swdt_state_t stateReg, stateNext;
  logic [7:0]   tickReg, tickNext, pendTickReg, pendTickNext;
  logic         unitReg, unitNext, pendUnitReg, pendUnitNext;
  logic         initReg, initNext;
  logic [7:0]   cntReg, cntNext;
  logic [5:0]   minReg, minNext;
  logic [PW-1:0] preReg, preNext;
  logic [4:0]   pulseReg, pulseNext;
  logic         okReg, okNext, failReg, failNext;
  logic [2:0]   stsReg, stsNext, mskReg, mskNext;
  logic [31:0]  rdataNext;
  logic         sysResetNext, irqNext;

  // Decodes one command bit of a control write
  function automatic logic cmdHit(input logic wr, input logic [7:0] a,
                                  input logic [31:0] d, input int bitN);
    cmdHit = wr && (a == swdt_pkg::CTRL_OFS) && d[bitN];
  endfunction

  logic cInit, cCfg, cArm, cKick, cHalt, tickEnd, expire;
  assign cInit = cmdHit(regWr, regAddr, regWdata, swdt_pkg::CMD_INIT_BIT);
  assign cCfg  = cmdHit(regWr, regAddr, regWdata, swdt_pkg::CMD_CFG_BIT);
  assign cArm  = cmdHit(regWr, regAddr, regWdata, swdt_pkg::CMD_ARM_BIT);
  assign cKick = cmdHit(regWr, regAddr, regWdata, swdt_pkg::CMD_KICK_BIT);
  assign cHalt = cmdHit(regWr, regAddr, regWdata, swdt_pkg::CMD_HALT_BIT);
  // A tick ends on the last prescaler cycle, and in minute mode on the 60th second
  assign tickEnd = (preReg == PW'(SEC_CYC - 1)) &&
                   (!unitReg || minReg == 6'(MIN_SEC - 1));
  // A halt, arm or kick taken in the last cycle wins over expiry; an initialize or
  // configure in the same write outranks those commands, so expiry then goes ahead
  assign expire  = (stateReg == swdt_pkg::SWDT_ARMED) && tickEnd && (cntReg == 8'h01)
                   && (cInit || cCfg || !(cKick || cHalt || cArm));

  // Next state of controller, counter and command results
  always_comb begin
    stateNext    = stateReg;
    tickNext     = tickReg;
    unitNext     = unitReg;
    pendTickNext = pendTickReg;
    pendUnitNext = pendUnitReg;
    initNext     = initReg;
    cntNext      = cntReg;
    minNext      = minReg;
    preNext      = preReg;
    pulseNext    = pulseReg;
    okNext       = 1'b0;
    failNext     = 1'b0;
    sysResetNext = 1'b0;
    // Shadow copy of the requested timeout, committed by the configure command
    if (regWr && regAddr == swdt_pkg::CONFIG_OFS) begin
      pendTickNext = regWdata[swdt_pkg::CFG_TICK_LSB +: 8];
      pendUnitNext = regWdata[swdt_pkg::CFG_UNIT_BIT];
    end
    unique case (stateReg)
      swdt_pkg::SWDT_IDLE: begin
        preNext = '0;
        minNext = '0;
      end
      swdt_pkg::SWDT_ARMED: begin
        if (preReg == PW'(SEC_CYC - 1)) begin
          preNext = '0;
          if (unitReg) minNext = (minReg == 6'(MIN_SEC - 1)) ? 6'h00 : minReg + 6'h01;
        end else begin
          preNext = preReg + PW'(1);
        end
        if (tickEnd) cntNext = cntReg - 8'h01;
        if (expire) begin
          stateNext = swdt_pkg::SWDT_FIRE;
          pulseNext = 5'(swdt_pkg::RST_CYCLES);
        end
      end
      swdt_pkg::SWDT_FIRE: begin
        sysResetNext = 1'b1;
        pulseNext    = pulseReg - 5'h01;
        // back to idle with reset configuration
        if (pulseReg == 5'h01) begin
          stateNext = swdt_pkg::SWDT_IDLE;
          tickNext  = swdt_pkg::TICK_RST;
          unitNext  = swdt_pkg::UNIT_RST;
          initNext  = 1'b0;
          cntNext   = swdt_pkg::TICK_RST;
        end
      end
    endcase
    // command results; all refused during the reset pulse
    if (stateReg != swdt_pkg::SWDT_FIRE) begin
      if (cInit) begin
        initNext = 1'b1;
        okNext   = 1'b1;
      end else if (cCfg) begin
        if (initReg && pendTickReg != 8'h00) begin
          tickNext = pendTickReg;
          unitNext = pendUnitReg;
          okNext   = 1'b1;
        end else failNext = 1'b1;
      end else if (cHalt) begin
        if (initReg) begin
          stateNext = swdt_pkg::SWDT_IDLE;
          okNext    = 1'b1;
        end else failNext = 1'b1;
      end else if (cArm) begin
        if (initReg) begin
          stateNext = swdt_pkg::SWDT_ARMED;
          cntNext   = tickReg;
          preNext   = '0;
          minNext   = '0;
          okNext    = 1'b1;
        end else failNext = 1'b1;
      end else if (cKick) begin
        if (initReg && stateReg == swdt_pkg::SWDT_ARMED) begin
          cntNext = tickReg;
          preNext = '0;
          minNext = '0;
          okNext  = 1'b1;
        end else failNext = 1'b1;
      end
    end else if (cInit || cCfg || cArm || cKick || cHalt) begin
      failNext = 1'b1;
    end
  end

  // Controller registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg    <= swdt_pkg::SWDT_IDLE;
      tickReg     <= swdt_pkg::TICK_RST;
      unitReg     <= swdt_pkg::UNIT_RST;
      pendTickReg <= swdt_pkg::TICK_RST;
      pendUnitReg <= swdt_pkg::UNIT_RST;
      initReg     <= 1'b0;
      cntReg      <= swdt_pkg::TICK_RST;
      minReg      <= '0;
      preReg      <= '0;
      pulseReg    <= '0;
      okReg       <= 1'b0;
      failReg     <= 1'b0;
      sysReset    <= 1'b0;
    end else begin
      stateReg    <= stateNext;
      tickReg     <= tickNext;
      unitReg     <= unitNext;
      pendTickReg <= pendTickNext;
      pendUnitReg <= pendUnitNext;
      initReg     <= initNext;
      cntReg      <= cntNext;
      minReg      <= minNext;
      preReg      <= preNext;
      pulseReg    <= pulseNext;
      okReg       <= okNext;
      failReg     <= failNext;
      sysReset    <= sysResetNext;
    end
  end

  // Interrupts and read data; a new event wins over a write-one clear
  always_comb begin
    stsNext = stsReg;
    mskNext = mskReg;
    if (regWr && regAddr == swdt_pkg::IRQ_STS_OFS) stsNext = stsReg & ~regWdata[2:0];
    if (regWr && regAddr == swdt_pkg::IRQ_MSK_OFS) mskNext = regWdata[2:0];
    stsNext = stsNext | {expire, failNext, okNext};
    irqNext = |(stsNext & mskNext);
    rdataNext = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        swdt_pkg::CONFIG_OFS:  rdataNext = {23'h0, unitReg, tickReg};
        swdt_pkg::STATUS_OFS:  rdataNext = {28'h0, stateReg == swdt_pkg::SWDT_ARMED,
                                            initReg, failReg, okReg};
        swdt_pkg::COUNT_OFS:   rdataNext = {24'h0, cntReg};
        swdt_pkg::IRQ_STS_OFS: rdataNext = {29'h0, stsReg};
        swdt_pkg::IRQ_MSK_OFS: rdataNext = {29'h0, mskReg};
        default:               rdataNext = 32'h0000_0000;
      endcase
    end
  end

  // Interrupt and read registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stsReg   <= '0;
      mskReg   <= swdt_pkg::MSK_RST;
      irq      <= 1'b0;
      regRdata <= '0;
    end else begin
      stsReg   <= stsNext;
      mskReg   <= mskNext;
      irq      <= irqNext;
      regRdata <= rdataNext;
    end
  end

  // Expiry sequence: last tick, then reset pulse two cycles later
  sequence lastTick_s;
    expire;
  endsequence
  sequence pulse_s;
    sysReset [*2];
  endsequence

  expiry_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    lastTick_s |=> ##1 pulse_s) else $error("no reset after expiry");
  // reset only from an armed expiry
  idle_no_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sysReset) |-> $past(expire, 2))
    else $error("reset without armed expiry");
  zero_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    cCfg && !cInit && stateReg != swdt_pkg::SWDT_FIRE && pendTickReg == 8'h00 |=>
    failReg && tickReg == $past(tickReg))
    else $error("zero tick accepted");
  kick_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    cKick && !cInit && !cCfg && !cHalt && initReg && stateReg == swdt_pkg::SWDT_ARMED
    |=> cntReg == tickReg && okReg)
    else $error("kick did not reload");
  // halt stops; a back-to-back arm may restart it
  halt_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    cHalt && !cInit && !cCfg && initReg && stateReg != swdt_pkg::SWDT_FIRE |=>
    stateReg == swdt_pkg::SWDT_IDLE ##1 (stateReg == swdt_pkg::SWDT_IDLE || $past(cArm)))
    else $error("halt did not stop");
  cmd_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cInit || cCfg || cArm || cKick || cHalt) |=> okReg ^ failReg)
    else $error("command without result");
  cfg_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
    stateReg == swdt_pkg::SWDT_FIRE && pulseReg == 5'h01 |=>
    stateReg == swdt_pkg::SWDT_IDLE && tickReg == swdt_pkg::TICK_RST)
    else $error("config not restored");
  sec_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    stateReg == swdt_pkg::SWDT_ARMED && !unitReg && preReg == PW'(SEC_CYC - 1)
    && !cKick && !cHalt && !cArm && cntReg > 8'h01 |=> cntReg == $past(cntReg) - 8'h01)
    else $error("second tick missed");
  // minute ticks only on the 60th second
  min_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    stateReg == swdt_pkg::SWDT_ARMED && unitReg && minReg != 6'(MIN_SEC - 1)
    && !cKick && !cArm |=> cntReg == $past(cntReg)) else $error("minute tick early");
endmodule

// ==== tb/swdt_host.sv ====
// Host driver model: register writes and reads on the plain port
module swdt_host (
  // Clock
  input  wire logic        clk,
  // Register port
  input  wire logic [31:0] regRdata,
  output logic      [7:0]  regAddr,
  output logic      [31:0] regWdata,
  output logic             regWr,
  output logic             regRd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle from time zero
  initial begin
    regAddr  = 8'h00;
    regWdata = 32'h0;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  // One-cycle write; the slave never stalls, so no wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule

// ==== tb/swdt_core_bench.sv ====
// Self-checking bench for the watchdog core
module swdt_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Short second and minute keep the run brief
  localparam int SC = 10;
  localparam int MS = 3;
  logic        clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        sysReset;
  logic        irq;
  logic [31:0] d;
  int          fails;
  int          nChecks;

  swdt_core #(.SEC_CYC(SC), .MIN_SEC(MS)) i_dut (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sysReset(sysReset), .irq(irq));
  swdt_host i_host (.clk(clk), .regRdata(regRdata), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

  // Clock of 40 ns
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Command with its outcome read back from the sticky flags
  task automatic cmd(input int b, input logic ok, input string msg);
    i_host.wr(swdt_pkg::IRQ_STS_OFS, 32'h7);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h1 << b);
    i_host.rd(swdt_pkg::IRQ_STS_OFS, d);
    chk(d[1:0], ok ? 2'b01 : 2'b10, msg);
  endtask

  task automatic prep(input logic [7:0] tick, input logic unit);
    cmd(swdt_pkg::CMD_INIT_BIT, 1'b1, "init");
    i_host.wr(swdt_pkg::CONFIG_OFS, {23'h0, unit, tick});
    cmd(swdt_pkg::CMD_CFG_BIT, 1'b1, "configure");
  endtask

  // Cycles from the arming edge to the reset pulse, then its width
  task automatic to_fire(input int lo, input string msg);
    int n;
    n = 0;
    while (sysReset !== 1'b1 && n < lo + 5) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n >= lo && n <= lo + 4), 32'h1, msg);
    if (sysReset !== 1'b1) close_out();
    n = 0;
    while (sysReset === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, swdt_pkg::RST_CYCLES, "pulse width");
  endtask

  task automatic quiet(input int cyc, input string msg);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (sysReset !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0, msg);
  endtask

  // Reset values and commands refused before init
  task automatic t_reset();
    i_host.rd(swdt_pkg::IRQ_MSK_OFS, d);
    chk(d, 32'h0, "mask reset");
    i_host.rd(swdt_pkg::STATUS_OFS, d);
    chk(d, 32'h0, "status reset");
    cmd(swdt_pkg::CMD_ARM_BIT, 1'b0, "arm before init");
    cmd(swdt_pkg::CMD_KICK_BIT, 1'b0, "kick before init");
    $display("test reset done");
  endtask

  // Zero count refused, kick refused while idle, idle never fires
  task automatic t_config();
    prep(8'hff, 1'b0);
    i_host.wr(swdt_pkg::CONFIG_OFS, 32'h0);
    cmd(swdt_pkg::CMD_CFG_BIT, 1'b0, "zero ticks");
    cmd(swdt_pkg::CMD_KICK_BIT, 1'b0, "kick idle");
    quiet(60, "idle fired");
    $display("test config done");
  endtask

  // Expiry in seconds, interrupt, then default configuration
  task automatic t_expiry();
    prep(8'h03, 1'b0);
    i_host.wr(swdt_pkg::IRQ_MSK_OFS, 32'h4);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    to_fire(3 * SC, "three seconds");
    chk(irq, 1'b1, "irq on expiry");
    i_host.rd(swdt_pkg::IRQ_STS_OFS, d);
    chk(d[2:0], 3'b101, "arm ok and expiry");
    i_host.rd(swdt_pkg::STATUS_OFS, d);
    chk(d[3:2], 2'b00, "idle after expiry");
    i_host.rd(swdt_pkg::CONFIG_OFS, d);
    chk(d, {23'h0, swdt_pkg::UNIT_RST, swdt_pkg::TICK_RST}, "config restored");
    i_host.wr(swdt_pkg::IRQ_STS_OFS, 32'h7);
    @(posedge clk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    cmd(swdt_pkg::CMD_INIT_BIT, 1'b1, "reinit");
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    to_fire(SC, "default one tick");
    $display("test expiry done");
  endtask

  // host kicks in time; kick restarts the full count
  task automatic t_kick();
    prep(8'h03, 1'b0);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    // Read takes two edges, so the wait is two shorter to keep the kick timing
    i_host.rd(swdt_pkg::COUNT_OFS, d);
    chk(d, 32'h3, "count loaded");
    repeat (23) @(posedge clk);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h8);
    to_fire(3 * SC, "kick reload");
    $display("test kick done");
  endtask

  // Halt holds off expiry until armed again
  task automatic t_halt();
    prep(8'h02, 1'b0);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    repeat (5) @(posedge clk);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h10);
    quiet(80, "halted fired");
    i_host.rd(swdt_pkg::COUNT_OFS, d);
    chk(d, 32'h2, "count frozen");
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    to_fire(2 * SC, "rearm");
    $display("test halt done");
  endtask

  // Minute ticks
  task automatic t_minute();
    prep(8'h02, 1'b1);
    i_host.wr(swdt_pkg::CTRL_OFS, 32'h4);
    to_fire(2 * MS * SC, "two minutes");
    $display("test minute done");
  endtask

  // Reset held for 12 cycles, then the scenarios
  initial begin
    fails   = 0;
    nChecks = 0;
    rst_n   = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk(sysReset, 1'b0, "reset out idle");
    t_reset();
    t_config();
    t_expiry();
    t_kick();
    t_halt();
    t_minute();
    close_out();
  end
endmodule
